// *** design/rtcal_pkg.sv ***
package rtcal_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] RTCAL_ADDR_SECONDS  = 4'h0;    // timekeeping seconds
	localparam logic [3:0] RTCAL_ADDR_MINUTES  = 4'h1;    // timekeeping minutes
	localparam logic [3:0] RTCAL_ADDR_HOURS    = 4'h2;    // timekeeping hours
	localparam logic [3:0] RTCAL_ADDR_WEEKDAY  = 4'h3;    // timekeeping day of week
	localparam logic [3:0] RTCAL_ADDR_MONTHDAY = 4'h4;    // timekeeping day of month
	localparam logic [3:0] RTCAL_ADDR_MONTH    = 4'h5;    // timekeeping month and century
	localparam logic [3:0] RTCAL_ADDR_YEAR     = 4'h6;    // timekeeping year
	localparam logic [3:0] RTCAL_ADDR_A1_FIRST = 4'h7;    // first alarm: seconds
	localparam logic [3:0] RTCAL_ADDR_A1_LAST  = 4'ha;    // first alarm: day/date
	localparam logic [3:0] RTCAL_ADDR_A2_FIRST = 4'hb;    // second alarm: minutes
	localparam logic [3:0] RTCAL_ADDR_A2_LAST  = 4'hd;    // second alarm: day/date
	localparam logic [3:0] RTCAL_ADDR_CTRL     = 4'he;    // alarm_routing_control
	localparam logic [3:0] RTCAL_ADDR_STATUS   = 4'hf;    // alarm_oscillator_flags

	// alarm storage indices (offset minus first alarm offset)
	localparam logic [2:0] RTCAL_A1_SEC = 3'h0;
	localparam logic [2:0] RTCAL_A1_MIN = 3'h1;
	localparam logic [2:0] RTCAL_A1_HR  = 3'h2;
	localparam logic [2:0] RTCAL_A1_DAY = 3'h3;
	localparam logic [2:0] RTCAL_A2_MIN = 3'h4;
	localparam logic [2:0] RTCAL_A2_HR  = 3'h5;
	localparam logic [2:0] RTCAL_A2_DAY = 3'h6;
	localparam int         RTCAL_NUM_ALARM_REGS = 7;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int RTCAL_MASK_BIT   = 7;    // per-field alarm mask
	localparam int RTCAL_DAYSEL_BIT = 6;    // weekday_or_monthday_select
	localparam int RTCAL_OSCOFF_BIT = 7;    // oscillator_enable_n
	localparam int RTCAL_RS_HI_BIT  = 4;    // square_rate_sel_hi
	localparam int RTCAL_RS_LO_BIT  = 3;    // square_rate_sel_lo
	localparam int RTCAL_ROUTE_BIT  = 2;    // irq_routing_select
	localparam int RTCAL_A2EN_BIT   = 1;    // alarm2_irq_enable
	localparam int RTCAL_A1EN_BIT   = 0;    // alarm1_irq_enable
	localparam int RTCAL_STOPF_BIT  = 7;    // oscillator_stop_flag
	localparam int RTCAL_A2FLG_BIT  = 1;    // alarm2_flag
	localparam int RTCAL_A1FLG_BIT  = 0;    // alarm1_flag

	// compare widths of the bcd fields
	localparam logic [7:0] RTCAL_TIME_FIELD = 8'h7f;    // seconds, minutes, hours
	localparam logic [7:0] RTCAL_DAY_FIELD  = 8'h3f;    // day or date value
	localparam logic [7:0] RTCAL_ZERO_SEC   = 8'h00;    // top of the minute

	// ----------------------------------------------------------------
	// reset values and writable bits
	// ----------------------------------------------------------------
	localparam logic [7:0] RTCAL_CTRL_RESET   = 8'h18;    // oscillator on, 32.768kHz, square out
	localparam logic [7:0] RTCAL_CTRL_WMASK   = 8'h9f;    // implemented control bits
	localparam logic [7:0] RTCAL_STATUS_RESET = 8'h80;    // stop flag set at power-up
	localparam logic [7:0] RTCAL_STATUS_MASK  = 8'h83;    // implemented status bits
	localparam logic [7:0] RTCAL_ALARM_RESET  = 8'h00;    // alarm registers

	// square-wave rate codes
	typedef enum logic [1:0] {
		RTCAL_RATE_1HZ  = 2'b00,
		RTCAL_RATE_4K   = 2'b01,
		RTCAL_RATE_8K   = 2'b10,
		RTCAL_RATE_32K  = 2'b11
	} rtcal_rate_t;

	// ----------------------------------------------------------------
	// timebase divider (osc_clk runs at twice 32.768kHz)
	// ----------------------------------------------------------------
	localparam int RTCAL_DIV_W   = 16;    // prescaler width
	localparam int RTCAL_TAP_32K = 0;     // 32.768kHz
	localparam int RTCAL_TAP_8K  = 2;     // 8.192kHz
	localparam int RTCAL_TAP_4K  = 3;     // 4.096kHz
	localparam int RTCAL_TAP_1HZ = 15;    // 1Hz

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int RTCAL_CLK_PERIOD_NS     = 20;        // 50 MHz system clock
	localparam int RTCAL_OSC_STOP_TIME_NS  = 250000;    // silence that counts as a stop
	localparam int RTCAL_OSC_STOP_CYCLES   = RTCAL_OSC_STOP_TIME_NS / RTCAL_CLK_PERIOD_NS;
	localparam int RTCAL_WD_W              = 16;        // watchdog counter width

endpackage : rtcal_pkg

// *** design/rtcal_sync.sv ***
`timescale 1ns/10ps

module rtcal_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,      // destination clock
	input  wire logic         rst_n,    // synchronous reset, active low
	input  wire logic [W-1:0] d,        // asynchronous levels
	output logic      [W-1:0] q         // synchronised levels
);

	// ----------------------------------------------------------------
	// two-stage state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] meta;    // first stage, read only by the second
		logic [W-1:0] sync;    // second stage
	} rtcal_sync_state_t;

	rtcal_sync_state_t s_r;     // registered state
	rtcal_sync_state_t s_nxt;   // next state

	// shift the levels through two flops
	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = d;
		s_nxt.sync = s_r.meta;
		if (!rst_n) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	assign q = s_r.sync;

endmodule : rtcal_sync

// *** design/rtcal_osc_div.sv ***
`timescale 1ns/10ps

module rtcal_osc_div
	import rtcal_pkg::*;
(
	input  wire logic                   osc_clk,         // oscillator timebase
	input  wire logic                   rst_n,           // system reset, active low
	input  wire logic                   osc_enable_n,    // stop the timebase when high
	output logic      [RTCAL_DIV_W-1:0] div_cnt,         // prescaler taps
	output logic                        sec_toggle       // flips once per second
);

	// ----------------------------------------------------------------
	// oscillator-domain state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [RTCAL_DIV_W-1:0] cnt;    // prescaler
		logic                   tog;    // one-second event toggle
	} rtcal_div_state_t;

	rtcal_div_state_t s_r;      // registered state
	rtcal_div_state_t s_nxt;    // next state
	logic [1:0]       ctl_sy;   // synced reset and enable

	// reset and enable arrive from the system domain
	rtcal_sync #(
		.W (2)
	) u_ctl_sync (
		.clk   (osc_clk),
		.rst_n (1'b1),
		.d     ({rst_n, osc_enable_n}),
		.q     (ctl_sy)
	);

	// count while enabled, flip the toggle on each wrap
	always_comb begin
		s_nxt = s_r;
		if (!ctl_sy[0]) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
			if (&s_r.cnt) begin
				s_nxt.tog = ~s_r.tog;
			end
		end
		if (!ctl_sy[1]) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge osc_clk) begin
		s_r <= s_nxt;
	end

	assign div_cnt    = s_r.cnt;
	assign sec_toggle = s_r.tog;

endmodule : rtcal_osc_div

// *** design/rtcal_alarm_ctrl.sv ***
// Functional notes
// - two alarms at offsets 07h-0Ah and 0Bh-0Dh
// - bit 7 masks; all clear needs full match
// - bit 6 picks weekday or month day
// - first alarm mask decode, second to date
// - second alarm mask decode, minute to date
// - matches tested only on one-second update
// - match sets sticky alarm flag until cleared
// - writing zero clears flag, one keeps it
// - control bit 7 stops oscillator, zero at reset
// - control bits 4:3 pick rate, 11 at reset
// - control bit 2 routes alarms or square wave
// - control bit 1 enables second alarm interrupt
// - control bit 0 enables first alarm interrupt
// - pin low while flag and enable set
// - stop flag sets on stop, power-up, disable
// - alarm fields compared as bcd values
// - hours bit 6 selects 12-hour mode
`timescale 1ns/10ps

module rtcal_alarm_ctrl
	import rtcal_pkg::*;
#(
	parameter int OSC_STOP_CYCLES = RTCAL_OSC_STOP_CYCLES    // timebase silence before stop flag
) (
	input  wire logic       clk,                // system clock
	input  wire logic       rst_n,              // synchronous reset, active low
	input  wire logic       osc_clk,            // oscillator timebase, twice 32.768kHz
	input  wire logic [3:0] reg_addr,           // register offset
	input  wire logic       reg_wr,             // write strobe
	input  wire logic [7:0] reg_wdata,          // write data
	output logic      [7:0] reg_rdata,          // read data of last cycle's offset
	input  wire logic [7:0] tk_seconds,         // timekeeping seconds, bcd
	input  wire logic [7:0] tk_minutes,         // timekeeping minutes, bcd
	input  wire logic [7:0] tk_hours,           // timekeeping hours, bcd
	input  wire logic [7:0] tk_weekday,         // timekeeping day of week
	input  wire logic [7:0] tk_monthday,        // timekeeping day of month, bcd
	input  wire logic [7:0] tk_month,           // timekeeping month and century
	input  wire logic [7:0] tk_year,            // timekeeping year, bcd
	output logic            sec_update,         // one-second update strobe
	output logic            oscillator_enable_n,// oscillator stop request
	input  wire logic       first_irq_pin_n_in, // first interrupt pin level
	output logic            first_irq_pin_n_out,// first interrupt pin drive value
	output logic            first_irq_pin_n_oe, // first interrupt pin pulled low
	input  wire logic       square_or_second_irq_pin_in,  // shared pin level
	output logic            square_or_second_irq_pin_out, // shared pin drive value
	output logic            square_or_second_irq_pin_oe   // shared pin pulled low
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// all flops in one record
	typedef struct packed {
		logic [RTCAL_NUM_ALARM_REGS-1:0][7:0] alarm;    // alarm registers 07h-0Dh
		logic [7:0]                           ctrl;     // alarm_routing_control
		logic [7:0]                           status;   // alarm_oscillator_flags
		logic                                 tick_prev;// last synced second toggle
		logic                                 act_prev; // last synced activity tap
		logic [RTCAL_WD_W-1:0]                wd_cnt;   // cycles since timebase moved
		logic [7:0]                           rdata;    // read data
		logic                                 tick;     // update strobe
		logic                                 irq1_oe;  // first pin pulled low
		logic                                 irq2_oe;  // shared pin pulled low
	} rtcal_state_t;

	// state and next state
	rtcal_state_t           s_r;       // registered state
	rtcal_state_t           s_nxt;     // next state

	// oscillator side
	logic [RTCAL_DIV_W-1:0] div_cnt;   // prescaler, oscillator domain
	logic                   sec_tog;   // second toggle, oscillator domain
	logic [4:0]             osc_sy;    // synced {toggle, 1Hz, 4k, 8k, 32k}
	logic                   tick;      // one-second update, system domain
	logic                   active;    // timebase moved this cycle
	logic                   stopped;   // timebase silent or disabled
	logic                   square;    // selected square wave
	// offset decode
	logic [3:0]             a_off;     // offset relative to first alarm
	logic [2:0]             a_idx;     // alarm register index
	// field compares
	logic                   sec_eq;    // first alarm seconds equal
	logic                   min1_eq;   // first alarm minutes equal
	logic                   hr1_eq;    // first alarm hours equal
	logic                   day1_eq;   // first alarm day or date equal
	logic                   min2_eq;   // second alarm minutes equal
	logic                   hr2_eq;    // second alarm hours equal
	logic                   day2_eq;   // second alarm day or date equal
	// match and irq terms
	logic                   a1_hit;    // first alarm matches
	logic                   a2_hit;    // second alarm matches
	logic                   irq1_req;  // first alarm interrupt active
	logic                   irq2_req;  // second alarm interrupt active

	// ----------------------------------------------------------------
	// oscillator domain and crossing
	// ----------------------------------------------------------------
	// prescaler on the oscillator clock
	rtcal_osc_div u_div (
		.osc_clk      (osc_clk),
		.rst_n        (rst_n),
		.osc_enable_n (s_r.ctrl[RTCAL_OSCOFF_BIT]),
		.div_cnt      (div_cnt),
		.sec_toggle   (sec_tog)
	);

	// taps are slow levels; the second is a toggle event
	rtcal_sync #(
		.W (5)
	) u_osc_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({sec_tog,
		         div_cnt[RTCAL_TAP_1HZ],
		         div_cnt[RTCAL_TAP_4K],
		         div_cnt[RTCAL_TAP_8K],
		         div_cnt[RTCAL_TAP_32K]}),
		.q     (osc_sy)
	);

	// ----------------------------------------------------------------
	// alarm compare
	// ----------------------------------------------------------------
	// bcd fields compared bit for bit, hours include mode and pm bits
	always_comb begin
		sec_eq  = ((s_r.alarm[RTCAL_A1_SEC] ^ tk_seconds) & RTCAL_TIME_FIELD) == 8'h00;
		min1_eq = ((s_r.alarm[RTCAL_A1_MIN] ^ tk_minutes) & RTCAL_TIME_FIELD) == 8'h00;
		hr1_eq  = ((s_r.alarm[RTCAL_A1_HR] ^ tk_hours) & RTCAL_TIME_FIELD) == 8'h00;
		// second alarm fields
		min2_eq = ((s_r.alarm[RTCAL_A2_MIN] ^ tk_minutes) & RTCAL_TIME_FIELD) == 8'h00;
		hr2_eq  = ((s_r.alarm[RTCAL_A2_HR] ^ tk_hours) & RTCAL_TIME_FIELD) == 8'h00;
		// select bit picks day of week or day of month
		if (s_r.alarm[RTCAL_A1_DAY][RTCAL_DAYSEL_BIT]) begin
			day1_eq = ((s_r.alarm[RTCAL_A1_DAY] ^ tk_weekday) & RTCAL_DAY_FIELD) == 8'h00;
		end else begin
			day1_eq = ((s_r.alarm[RTCAL_A1_DAY] ^ tk_monthday) & RTCAL_DAY_FIELD) == 8'h00;
		end
		// same select, second alarm
		if (s_r.alarm[RTCAL_A2_DAY][RTCAL_DAYSEL_BIT]) begin
			day2_eq = ((s_r.alarm[RTCAL_A2_DAY] ^ tk_weekday) & RTCAL_DAY_FIELD) == 8'h00;
		end else begin
			day2_eq = ((s_r.alarm[RTCAL_A2_DAY] ^ tk_monthday) & RTCAL_DAY_FIELD) == 8'h00;
		end
		// a set mask drops its field; all clear demands every field
		a1_hit = (s_r.alarm[RTCAL_A1_SEC][RTCAL_MASK_BIT] | sec_eq)
		       & (s_r.alarm[RTCAL_A1_MIN][RTCAL_MASK_BIT] | min1_eq)
		       & (s_r.alarm[RTCAL_A1_HR][RTCAL_MASK_BIT] | hr1_eq)
		       & (s_r.alarm[RTCAL_A1_DAY][RTCAL_MASK_BIT] | day1_eq);
		// second alarm has no seconds field: it fires at 00 seconds
		a2_hit = (tk_seconds == RTCAL_ZERO_SEC)
		       & (s_r.alarm[RTCAL_A2_MIN][RTCAL_MASK_BIT] | min2_eq)
		       & (s_r.alarm[RTCAL_A2_HR][RTCAL_MASK_BIT] | hr2_eq)
		       & (s_r.alarm[RTCAL_A2_DAY][RTCAL_MASK_BIT] | day2_eq);
	end

	// ----------------------------------------------------------------
	// square wave and interrupt routing
	// ----------------------------------------------------------------
	always_comb begin
		// rate code picks a tap
		unique case (rtcal_rate_t'(s_r.ctrl[RTCAL_RS_HI_BIT:RTCAL_RS_LO_BIT]))
			RTCAL_RATE_1HZ: begin
				square = osc_sy[3];
			end
			RTCAL_RATE_4K: begin
				square = osc_sy[2];
			end
			RTCAL_RATE_8K: begin
				square = osc_sy[1];
			end
			// fastest tap, rough
			RTCAL_RATE_32K: begin
				square = osc_sy[0];
			end
		endcase
		// flag interrupts if enabled
		irq1_req = s_r.status[RTCAL_A1FLG_BIT] & s_r.ctrl[RTCAL_A1EN_BIT];
		irq2_req = s_r.status[RTCAL_A2FLG_BIT] & s_r.ctrl[RTCAL_A2EN_BIT];
	end

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		// hold, decode offset
		s_nxt   = s_r;
		a_off   = reg_addr - RTCAL_ADDR_A1_FIRST;
		a_idx   = a_off[2:0];
		// toggle change: one second
		tick    = osc_sy[4] ^ s_r.tick_prev;
		active  = osc_sy[2] ^ s_r.act_prev;
		// disabled or silent
		stopped = s_r.ctrl[RTCAL_OSCOFF_BIT] || (s_r.wd_cnt >= RTCAL_WD_W'(OSC_STOP_CYCLES));
		// keep last levels
		s_nxt.tick_prev = osc_sy[4];
		s_nxt.act_prev  = osc_sy[2];
		s_nxt.tick      = tick;
		// watchdog: restart on timebase movement, saturate when silent
		if (active) begin
			s_nxt.wd_cnt = '0;
		end else if (!stopped) begin
			// count silence
			s_nxt.wd_cnt = s_r.wd_cnt + 1'b1;
		end
		// register writes
		// effective next edge
		if (reg_wr) begin
			if (reg_addr >= RTCAL_ADDR_A1_FIRST && reg_addr <= RTCAL_ADDR_A2_LAST) begin
				// all bits kept
				s_nxt.alarm[a_idx] = reg_wdata;
			end else if (reg_addr == RTCAL_ADDR_CTRL) begin
				// unused bits stay zero
				s_nxt.ctrl = reg_wdata & RTCAL_CTRL_WMASK;
			end else if (reg_addr == RTCAL_ADDR_STATUS) begin
				// zero clears a flag, one leaves it
				s_nxt.status = s_r.status & reg_wdata & RTCAL_STATUS_MASK;
			end
		end
		// hardware sets win over a clear in the same cycle
		if (tick && a1_hit) begin
			s_nxt.status[RTCAL_A1FLG_BIT] = 1'b1;
		end
		if (tick && a2_hit) begin
			s_nxt.status[RTCAL_A2FLG_BIT] = 1'b1;
		end
		if (stopped) begin
			s_nxt.status[RTCAL_STOPF_BIT] = 1'b1;
		end
		// read data, one cycle after the offset
		// time read through
		if (reg_addr <= RTCAL_ADDR_YEAR) begin
			unique case (reg_addr)
				RTCAL_ADDR_SECONDS: begin
					s_nxt.rdata = tk_seconds;
				end
				RTCAL_ADDR_MINUTES: begin
					s_nxt.rdata = tk_minutes;
				end
				RTCAL_ADDR_HOURS: begin
					s_nxt.rdata = tk_hours;
				end
				RTCAL_ADDR_WEEKDAY: begin
					s_nxt.rdata = tk_weekday;
				end
				RTCAL_ADDR_MONTHDAY: begin
					s_nxt.rdata = tk_monthday;
				end
				RTCAL_ADDR_MONTH: begin
					s_nxt.rdata = tk_month;
				end
				default: begin
					s_nxt.rdata = tk_year;
				end
			endcase
		end else if (reg_addr == RTCAL_ADDR_CTRL) begin
			s_nxt.rdata = s_r.ctrl;
		end else if (reg_addr == RTCAL_ADDR_STATUS) begin
			// flags as stored
			s_nxt.rdata = s_r.status;
		end else begin
			// alarms by index
			s_nxt.rdata = s_r.alarm[a_idx];
		end
		// routing: first pin always, shared pin square or second alarm
		if (s_r.ctrl[RTCAL_ROUTE_BIT]) begin
			s_nxt.irq1_oe = irq1_req;
			s_nxt.irq2_oe = irq2_req;
		end else begin
			s_nxt.irq1_oe = irq1_req | irq2_req;
			// low in square's low half
			s_nxt.irq2_oe = ~square;
		end
		// power-up values
		if (!rst_n) begin
			s_nxt        = '0;
			// alarms arbitrary, zero
			s_nxt.alarm  = {RTCAL_NUM_ALARM_REGS{RTCAL_ALARM_RESET}};
			s_nxt.ctrl   = RTCAL_CTRL_RESET;
			s_nxt.status = RTCAL_STATUS_RESET;
		end
	end

	// one register stage
	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// flops or tied low
	assign reg_rdata                    = s_r.rdata;
	assign sec_update                   = s_r.tick;
	assign oscillator_enable_n          = s_r.ctrl[RTCAL_OSCOFF_BIT];
	assign first_irq_pin_n_out          = s_r.wd_cnt[RTCAL_WD_W-1] & 1'b0;
	assign first_irq_pin_n_oe           = s_r.irq1_oe;
	assign square_or_second_irq_pin_out = s_r.wd_cnt[RTCAL_WD_W-1] & 1'b0;
	assign square_or_second_irq_pin_oe  = s_r.irq2_oe;

endmodule : rtcal_alarm_ctrl

// *** verif/rtcal_alarm_ctrl_chk.sv ***
`timescale 1ns/10ps

module rtcal_alarm_ctrl_chk
	import rtcal_pkg::*;
#(
	parameter int OSC_STOP_CYCLES = RTCAL_OSC_STOP_CYCLES    // same as the design
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       sec_update,
	input  wire logic       oscillator_enable_n,
	input  wire logic       first_irq_pin_n_out,
	input  wire logic       first_irq_pin_n_oe,
	input  wire logic       square_or_second_irq_pin_out,
	input  wire logic       square_or_second_irq_pin_oe
);
	// ----------------------------------------------------------------
	// properties on the system clock
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_pins_open_drain: assert property (!first_irq_pin_n_out && !square_or_second_irq_pin_out)
		else $error("interrupt pin drive value not low");
	a_reset_values: assert property ($rose(rst_n) |-> reg_rdata == 8'h00 && !oscillator_enable_n)
		else $error("outputs not cleared by reset");
	a_ctrl_readback: assert property ((reg_wr && reg_addr == 4'he) ##1 (!reg_wr && reg_addr == 4'he)
		|=> reg_rdata == ($past(reg_wdata, 2) & 8'h9f)) else $error("control readback wrong");
	a_osc_follows_ctrl: assert property ((reg_wr && reg_addr == 4'he) ##1 !(reg_wr && reg_addr == 4'he)
		|=> oscillator_enable_n == $past(reg_wdata[7], 2)) else $error("oscillator enable not control bit 7");
	a_ctrl_unused: assert property (reg_addr == 4'he |=> reg_rdata[6:5] == 2'b00)
		else $error("unused control bits not zero");
	a_status_unused: assert property (reg_addr == 4'hf |=> reg_rdata[6:2] == 5'h00)
		else $error("unused status bits not zero");
	a_sec_one_pulse: assert property (sec_update |=> !sec_update [*8])
		else $error("second update not a single pulse");
	a_irq_rise_cause: assert property ($rose(first_irq_pin_n_oe) |-> $past(sec_update) || $past(sec_update, 2)
		|| $past(reg_wr) || $past(reg_wr, 2)) else $error("interrupt rose without tick or write");
	a_irq_fall_cause: assert property ($fell(first_irq_pin_n_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("interrupt fell without a write");

	// main scenarios reached
	c_tick: cover property (sec_update);
	c_irq_first: cover property ($rose(first_irq_pin_n_oe));
	c_irq_shared: cover property ($rose(square_or_second_irq_pin_oe));

endmodule : rtcal_alarm_ctrl_chk

bind rtcal_alarm_ctrl rtcal_alarm_ctrl_chk #(.OSC_STOP_CYCLES(OSC_STOP_CYCLES)) u_chk (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .sec_update(sec_update), .oscillator_enable_n(oscillator_enable_n),
	.first_irq_pin_n_out(first_irq_pin_n_out), .first_irq_pin_n_oe(first_irq_pin_n_oe),
	.square_or_second_irq_pin_out(square_or_second_irq_pin_out),
	.square_or_second_irq_pin_oe(square_or_second_irq_pin_oe));

// *** verif/rtcal_tk_model.sv ***
`timescale 1ns/10ps

module rtcal_tk_model (
	input  wire logic       osc_stop,       // oscillator stop request
	output logic            osc_clk,        // crystal timebase, 32 ns
	output logic      [7:0] tk_seconds,     // bcd time values
	output logic      [7:0] tk_minutes,
	output logic      [7:0] tk_hours,
	output logic      [7:0] tk_weekday,
	output logic      [7:0] tk_monthday,
	output logic      [7:0] tk_month,
	output logic      [7:0] tk_year
);
	// crystal stands still while stopped, phase unrelated to clk
	initial begin
		osc_clk = 1'b0;
		#7;
		forever begin
			#16;
			osc_clk = osc_stop ? 1'b0 : ~osc_clk;
		end
	end

	// calendar fixed, time loaded by the bench
	initial begin
		tk_month = 8'h01;
		tk_year  = 8'h24;
		set_time(8'h00, 8'h00, 8'h00, 8'h01, 8'h01);
	end

	// load a bcd time of day
	task automatic set_time(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h,
		input logic [7:0] wd, input logic [7:0] md);
		tk_seconds  <= s;
		tk_minutes  <= m;
		tk_hours    <= h;
		tk_weekday  <= wd;
		tk_monthday <= md;
	endtask : set_time

endmodule : rtcal_tk_model

// *** verif/rtcal_alarm_ctrl_tb.sv ***
`timescale 1ns/10ps

module rtcal_alarm_ctrl_tb;
	import rtcal_pkg::*;

	logic       clk = 1'b0, rst_n, reg_wr, sec_update, osc_en_n, osc_clk;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, tk_s, tk_m, tk_h, tk_wd, tk_md, tk_mo, tk_y;
	logic       a_out, a_oe, b_out, b_oe;
	wire logic  a_pin = a_oe ? 1'b0 : 1'b1;    // pulled-up open-drain levels
	wire logic  b_pin = b_oe ? 1'b0 : 1'b1;
	int         miscompares, num_checks;

	always #10 clk = ~clk;

	rtcal_tk_model u_tk (.osc_stop(osc_en_n), .osc_clk(osc_clk), .tk_seconds(tk_s), .tk_minutes(tk_m),
		.tk_hours(tk_h), .tk_weekday(tk_wd), .tk_monthday(tk_md), .tk_month(tk_mo), .tk_year(tk_y));

	rtcal_alarm_ctrl #(.OSC_STOP_CYCLES(300)) u_dut (.clk(clk), .rst_n(rst_n), .osc_clk(osc_clk),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.tk_seconds(tk_s), .tk_minutes(tk_m), .tk_hours(tk_h), .tk_weekday(tk_wd), .tk_monthday(tk_md),
		.tk_month(tk_mo), .tk_year(tk_y), .sec_update(sec_update), .oscillator_enable_n(osc_en_n),
		.first_irq_pin_n_in(a_pin), .first_irq_pin_n_out(a_out), .first_irq_pin_n_oe(a_oe),
		.square_or_second_irq_pin_in(b_pin), .square_or_second_irq_pin_out(b_out),
		.square_or_second_irq_pin_oe(b_oe));

	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wr    <= 1'b1;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task automatic rd_chk(input string n, input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		settle;
		chk(n, e, reg_rdata);
	endtask : rd_chk

	// write the seven alarm registers and read each back
	task automatic alarms(input logic [7:0] v [7]);
		for (int i = 0; i < 7; i++) begin
			wr(4'h7 + i[3:0], v[i]);
			rd_chk("alarm_reg", 4'h7 + i[3:0], v[i]);
		end
	endtask : alarms

	// wait for the one-second update, bounded
	task automatic wait_tick;
		int n;
		n = 0;
		while (sec_update !== 1'b1 && n < 120000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 120000) chk("sec_update", 8'h01, {7'h00, sec_update});
	endtask : wait_tick

	// shared-pin edges in 64 cycles, square routed out
	task automatic sq_chk(input string n, input logic [1:0] rs, input int lo, input int hi);
		int   e;
		logic p;
		wr(4'he, {3'h0, rs, 3'h0});
		settle;
		e = 0;
		p = b_oe;
		repeat (64) begin
			@(posedge clk);
			#1;
			e += int'(b_oe !== p);
			p = b_oe;
		end
		chk(n, 8'h01, {7'h00, e >= lo && e <= hi});
	endtask : sq_chk

	task automatic complete_run;
		if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run

	// watchdog over four ticks worth of cycles
	initial begin
		repeat (450000) @(posedge clk);
		miscompares++;
		complete_run;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		miscompares = 0;
		num_checks = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		u_tk.set_time(8'h00, 8'h30, 8'h12, 8'h03, 8'h05);
		rd_chk("ctrl_reset", 4'he, 8'h18);
		rd_chk("status_reset", 4'hf, 8'h80);
		wr(4'he, 8'hff);
		rd_chk("ctrl_unused", 4'he, 8'h9f);
		chk("osc_enable_n", 8'h01, {7'h00, osc_en_n});
		wr(4'hf, 8'h00);
		rd_chk("osf_held", 4'hf, 8'h80);
		// seconds-only first alarm, hours and minutes second alarm
		wr(4'he, 8'h07);
		alarms('{8'h00, 8'h80, 8'h80, 8'h80, 8'h30, 8'h12, 8'h80});
		wr(4'hf, 8'h00);
		rd_chk("flags_clear", 4'hf, 8'h00);
		wait_tick;
		rd_chk("both_flags", 4'hf, 8'h03);
		chk("first_pin", 8'h01, {7'h00, a_oe});
		chk("shared_pin", 8'h01, {7'h00, b_oe});
		wr(4'he, 8'h02);
		settle;
		chk("first_pin_a2", 8'h01, {7'h00, a_oe});
		wr(4'he, 8'h00);
		settle;
		chk("first_pin_off", 8'h00, {7'h00, a_oe});
		wr(4'hf, 8'hff);
		rd_chk("flags_kept", 4'hf, 8'h03);
		wr(4'hf, 8'hfd);
		rd_chk("a2_cleared", 4'hf, 8'h01);
		// full first alarm on weekday, second alarm needs zero seconds
		wr(4'he, 8'h06);
		u_tk.set_time(8'h01, 8'h30, 8'h12, 8'h03, 8'h05);
		alarms('{8'h01, 8'h30, 8'h12, 8'h43, 8'h30, 8'h12, 8'h80});
		wr(4'hf, 8'h00);
		rd_chk("flags_clear2", 4'hf, 8'h00);
		wait_tick;
		rd_chk("weekday_hit", 4'hf, 8'h01);
		chk("first_pin_masked", 8'h00, {7'h00, a_oe});
		chk("shared_pin_idle", 8'h00, {7'h00, b_oe});
		sq_chk("square_4k", 2'b01, 4, 6);
		sq_chk("square_8k", 2'b10, 9, 11);
		complete_run;
	end

endmodule : rtcal_alarm_ctrl_tb
